/* src/ppg_defines.svh */
// Register offsets, field positions, reset values and mode and counter constants
`ifndef PPG_DEFINES_SVH
`define PPG_DEFINES_SVH
`define OFS_MODE_A 12'h000
`define OFS_DUTY_A 12'h004
`define OFS_CYCLE_A 12'h008
`define OFS_MODE_B 12'h00C
`define OFS_DUTY_B 12'h010
`define OFS_CYCLE_B 12'h014
`define OFS_PAIR_CTRL 12'h018
`define OFS_STATUS 12'h01C
`define MODE_CLK_LSB 0
`define MODE_OP_LSB 4
`define MODE_EXT_BIT 3
`define MODE_LEVEL_BIT 6
`define MODE_DBUF_BIT 7
`define CTRL_RUN_A_BIT 0
`define CTRL_RUN_B_BIT 1
`define CTRL_CASCADE_BIT 2
`define CTRL_AND_BIT 3
`define MODE_RESET 8'h00
`define CMP_RESET 8'h00
`define OP_MODE_PPG 2'h2
`define COUNT_CLEAR 8'h00
`endif

/* src/ppg_pkg.sv */
// Types shared by the pulse pattern timer files
package ppg_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1
  } chan_state_t;
endpackage

/* src/ppg_chan_if.sv */
// Control and status carried between the top and one timer channel
`timescale 1ns/10ps
interface ppg_chan_if;
  logic [7:0] mode; // Mode register value
  logic run; // Channel run bit
  logic tick; // Source clock tick
  logic duty_we; // Write strobe to duty compare
  logic cycle_we; // Write strobe to cycle compare
  logic [7:0] wdata; // Write data
  logic [7:0] duty_rd; // Duty compare read value
  logic [7:0] cycle_rd; // Cycle compare read value
  logic out_level; // Channel pulse level
  logic match_pulse; // Cycle match event
  logic [7:0] count; // Counter value
  modport top (output mode, run, tick, duty_we, cycle_we, wdata,
               input duty_rd, cycle_rd, out_level, match_pulse, count);
  modport chan (input mode, run, tick, duty_we, cycle_we, wdata,
                output duty_rd, cycle_rd, out_level, match_pulse, count);
endinterface

/* src/ppg_channel.sv */
// One pulse pattern timer channel: counter, compares, output flip-flop
`timescale 1ns/10ps
module ppg_channel
  import ppg_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  ppg_chan_if.chan ch
);
  `include "ppg_defines.svh"
  byte_t count; // Up counter
  byte_t duty_act; // Active duty compare
  byte_t cycle_act; // Active cycle compare
  byte_t duty_buf; // Buffered duty value
  byte_t cycle_buf; // Buffered cycle value
  logic level; // Toggle flip-flop
  logic dbuf; // Double buffer on
  logic idle_lvl; // Idle level select
  logic duty_hit; // Duty match
  logic cycle_hit; // Cycle match
  chan_state_t state; // Run state
  byte_t next_count; // Count after the next tick, wraps at the top
  logic duty_eq_wr; // Unbuffered duty write equal to the count
  logic cycle_eq_wr; // Unbuffered cycle write equal to the count

  assign dbuf = ch.mode[`MODE_DBUF_BIT];
  assign idle_lvl = ch.mode[`MODE_LEVEL_BIT];
  assign next_count = count + 8'h01;
  // A match is the tick on which the counter reaches a compare value, so the
  // cycle compare value itself is the period in source clocks
  // An unbuffered write equal to the present count matches at once, off the tick
  assign duty_eq_wr = ch.run && !dbuf && ch.duty_we && (ch.wdata == count);
  assign cycle_eq_wr = ch.run && !dbuf && ch.cycle_we && (ch.wdata == count);
  assign duty_hit = (ch.run && ch.tick && (next_count == duty_act)) || duty_eq_wr;
  assign cycle_hit = (ch.run && ch.tick && (next_count == cycle_act)) || cycle_eq_wr;

  // Run state
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state <= ST_IDLE;
    end else begin
      state <= ch.run ? ST_RUN : ST_IDLE;
    end
  end

  // Counter: counts ticks, clears on cycle match, wraps, clears on stop
  always_ff @(posedge clk_i) begin
    if (srst_i || !ch.run) begin
      count <= `COUNT_CLEAR;
    end else if (cycle_hit) begin
      count <= `COUNT_CLEAR;
    end else if (ch.tick) begin
      count <= next_count;
    end
  end

  // Output level: idle when stopped, leaves idle on duty match, returns to idle on cycle match
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      level <= 1'b0;
    end else if (!ch.run) begin
      level <= idle_lvl;
    end else if (cycle_hit) begin
      level <= idle_lvl;
    end else if (duty_hit && level == idle_lvl) begin
      level <= ~idle_lvl;
    end
  end

  // Buffers always take writes; reads show the last written value
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      duty_buf <= `CMP_RESET;
      cycle_buf <= `CMP_RESET;
    end else begin
      if (ch.duty_we) begin
        duty_buf <= ch.wdata;
      end
      if (ch.cycle_we) begin
        cycle_buf <= ch.wdata;
      end
    end
  end

  // Active compares: direct, or loaded from buffer on cycle match
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      duty_act <= `CMP_RESET;
      cycle_act <= `CMP_RESET;
    end else if (dbuf && ch.run) begin
      if (cycle_hit) begin
        duty_act <= ch.duty_we ? ch.wdata : duty_buf;
        cycle_act <= ch.cycle_we ? ch.wdata : cycle_buf;
      end
    end else begin
      if (ch.duty_we) begin
        duty_act <= ch.wdata;
      end
      if (ch.cycle_we) begin
        cycle_act <= ch.wdata;
      end
    end
  end

  assign ch.duty_rd = dbuf ? duty_buf : duty_act;
  assign ch.cycle_rd = dbuf ? cycle_buf : cycle_act;
  assign ch.out_level = level;
  assign ch.match_pulse = cycle_hit;
  assign ch.count = count;

  a_stop_clears: assert property (@(posedge clk_i) disable iff (srst_i)
    (state == ST_RUN && !ch.run) |=> (count == 8'h00 && level == $past(idle_lvl)))
    else $error("stop did not clear counter and level");
  a_cycle_restart: assert property (@(posedge clk_i) disable iff (srst_i)
    (ch.match_pulse && ch.run) |=> (!ch.run || count == 8'h00))
    else $error("cycle match did not clear counter");
  a_dbuf_hold: assert property (@(posedge clk_i) disable iff (srst_i)
    (dbuf && ch.run && ch.duty_we && !ch.match_pulse) |=> $stable(duty_act))
    else $error("buffered write reached active duty");
  a_direct_write: assert property (@(posedge clk_i) disable iff (srst_i)
    (!dbuf && ch.duty_we) |=> (duty_act == $past(ch.wdata)))
    else $error("direct duty write lost");
endmodule

/* src/ppg_timer.sv */
// Two-channel pulse pattern timer with APB register access
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// What this block does
// - Run starts counting; mode writes ignored
// - Level select sets idle output level
// - Stopped channel drives idle level out
// - Duty match toggles output away from idle
// - Cycle match returns idle, raises event
// - Stop clears counter, output to idle
// - AND enable drives both channels ANDed on pin B
// - Second channel behaves identically
// - Double buffer bit enables compare buffering
// - Running buffered writes go only buffer
// - Cycle match copies buffers to active
// - Buffered reads return last written value
// - Stopped buffered write updates both
// - Unbuffered writes take effect immediately
// - Passed compare waits for counter wrap
// - Equal compare matches right after write
module ppg_timer
  import ppg_pkg::*;
#(
  parameter int DIV_WIDTH = 12 // Width of source clock prescaler
)(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic pulse_a_o,
  output logic pulse_b_o,
  output logic cycle_match_irq_a_o,
  output logic cycle_match_irq_b_o
);
  `include "ppg_defines.svh"

  ////////////////////////////////////////////////////////////////////////
  // Registers and decode
  ////////////////////////////////////////////////////////////////////////
  ppg_chan_if ch_a(); // Channel A bundle
  ppg_chan_if ch_b(); // Channel B bundle
  byte_t mode_a; // Channel A mode
  byte_t mode_b; // Channel B mode
  logic run_a; // Channel A run
  logic run_b; // Channel B run
  logic cascade; // Cascade select, stored and read back but unused
  logic and_en; // AND output enable
  logic [DIV_WIDTH-1:0] prescale; // Free running prescaler
  logic [DIV_WIDTH-1:0] prescale_prev; // Prescaler one cycle ago
  logic wr_en; // APB write access
  logic rd_en; // APB read access
  logic mapped; // Address decodes
  logic [31:0] next_rdata; // Read mux

  // Address match helper
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  // Tick for a source select: one tap of the prescaler falls, or every clock for select 7
  function automatic logic tick_of(input logic [2:0] sel,
                                   input logic [DIV_WIDTH-1:0] now,
                                   input logic [DIV_WIDTH-1:0] prev);
    int tap;
    tap = 7 - int'(sel);
    if (sel == 3'h7) begin
      return 1'b1;
    end
    return prev[tap] && !now[tap];
  endfunction

  assign wr_en = psel_i && penable_i && pwrite_i;
  assign rd_en = psel_i && penable_i && !pwrite_i;
  assign mapped = hit(paddr_i, `OFS_MODE_A) || hit(paddr_i, `OFS_DUTY_A) ||
                  hit(paddr_i, `OFS_CYCLE_A) || hit(paddr_i, `OFS_MODE_B) ||
                  hit(paddr_i, `OFS_DUTY_B) || hit(paddr_i, `OFS_CYCLE_B) ||
                  hit(paddr_i, `OFS_PAIR_CTRL) || hit(paddr_i, `OFS_STATUS);

  // Mode registers accept writes only while their channel is stopped
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_a <= `MODE_RESET;
      mode_b <= `MODE_RESET;
    end else if (wr_en) begin
      if (hit(paddr_i, `OFS_MODE_A) && !run_a) begin
        mode_a <= pwdata_i[7:0];
      end
      if (hit(paddr_i, `OFS_MODE_B) && !run_b) begin
        mode_b <= pwdata_i[7:0];
      end
    end
  end

  // Pair control register
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      run_a <= 1'b0;
      run_b <= 1'b0;
      cascade <= 1'b0;
      and_en <= 1'b0;
    end else if (wr_en && hit(paddr_i, `OFS_PAIR_CTRL)) begin
      run_a <= pwdata_i[`CTRL_RUN_A_BIT];
      run_b <= pwdata_i[`CTRL_RUN_B_BIT];
      cascade <= pwdata_i[`CTRL_CASCADE_BIT];
      and_en <= pwdata_i[`CTRL_AND_BIT];
    end
  end

  // Prescaler produces source clock taps
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prescale <= '0;
      prescale_prev <= '0;
    end else begin
      prescale <= prescale + 1'b1;
      prescale_prev <= prescale;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channels
  ////////////////////////////////////////////////////////////////////////
  assign ch_a.mode = mode_a;
  assign ch_a.run = run_a;
  assign ch_a.tick = tick_of(mode_a[2:0], prescale, prescale_prev);
  assign ch_a.duty_we = wr_en && hit(paddr_i, `OFS_DUTY_A);
  assign ch_a.cycle_we = wr_en && hit(paddr_i, `OFS_CYCLE_A);
  assign ch_a.wdata = pwdata_i[7:0];
  assign ch_b.mode = mode_b;
  assign ch_b.run = run_b;
  assign ch_b.tick = tick_of(mode_b[2:0], prescale, prescale_prev);
  assign ch_b.duty_we = wr_en && hit(paddr_i, `OFS_DUTY_B);
  assign ch_b.cycle_we = wr_en && hit(paddr_i, `OFS_CYCLE_B);
  assign ch_b.wdata = pwdata_i[7:0];

  ppg_channel u_chan_a (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ch(ch_a.chan)
  );

  ppg_channel u_chan_b (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .ch(ch_b.chan)
  );

  ////////////////////////////////////////////////////////////////////////
  // Outputs
  ////////////////////////////////////////////////////////////////////////
  // Pulse pins and event pulses, all registered
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pulse_a_o <= 1'b0;
      pulse_b_o <= 1'b0;
      cycle_match_irq_a_o <= 1'b0;
      cycle_match_irq_b_o <= 1'b0;
    end else begin
      pulse_a_o <= ch_a.out_level;
      pulse_b_o <= and_en ? (ch_a.out_level & ch_b.out_level) : ch_b.out_level;
      cycle_match_irq_a_o <= ch_a.match_pulse;
      cycle_match_irq_b_o <= ch_b.match_pulse;
    end
  end

  // Read mux
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr_i)
      `OFS_MODE_A: next_rdata = {24'h000000, mode_a};
      `OFS_DUTY_A: next_rdata = {24'h000000, ch_a.duty_rd};
      `OFS_CYCLE_A: next_rdata = {24'h000000, ch_a.cycle_rd};
      `OFS_MODE_B: next_rdata = {24'h000000, mode_b};
      `OFS_DUTY_B: next_rdata = {24'h000000, ch_b.duty_rd};
      `OFS_CYCLE_B: next_rdata = {24'h000000, ch_b.cycle_rd};
      `OFS_PAIR_CTRL: next_rdata = {28'h0000000, and_en, cascade, run_b, run_a};
      `OFS_STATUS: next_rdata = {16'h0000, ch_b.count, ch_a.count};
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // APB answer: zero wait state, error on unmapped address
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      prdata_o <= next_rdata;
      pready_o <= 1'b1;
      pslverr_o <= psel_i && !penable_i && !mapped;
    end
  end

  a_mode_locked: assert property (@(posedge clk_i) disable iff (srst_i)
    (run_a && $past(run_a)) |-> $stable(mode_a))
    else $error("mode changed while running");
  a_and_output: assert property (@(posedge clk_i) disable iff (srst_i)
    and_en |=> (pulse_b_o == ($past(ch_a.out_level) & $past(ch_b.out_level))))
    else $error("AND output wrong");
  a_idle_level: assert property (@(posedge clk_i) disable iff (srst_i)
    (!run_a && !$past(run_a) && $stable(mode_a)) |=>
      (pulse_a_o == $past(mode_a[`MODE_LEVEL_BIT])))
    else $error("idle level not driven");
  a_irq_match: assert property (@(posedge clk_i) disable iff (srst_i)
    ch_a.match_pulse |=> cycle_match_irq_a_o)
    else $error("cycle match event missing");
endmodule

/* verif/ppg_load_model.sv */
// Load on a pulse pin: measures high width and period in clocks
`timescale 1ns/10ps
module ppg_load_model (
  input wire logic clk_i,
  input wire logic pin_i,
  output int hi_len_o,
  output int period_o
);
  logic last = 1'b0; // Pin level one clock ago
  int hi_cnt = 0; // Clocks spent high in this pulse
  int per_cnt = 0; // Clocks since the last rising edge
  initial begin
    hi_len_o = 0;
    period_o = 0;
  end
  ////////////////////////////////////////////////////////////////
  // Pure sink: it never drives the pin, it only times the pulses
  always @(posedge clk_i) begin
    last <= pin_i;
    per_cnt <= per_cnt + 1;
    // Count high clocks
    if (pin_i === 1'b1) begin
      hi_cnt <= hi_cnt + 1;
    end
    // Rising edge closes one period
    if (pin_i === 1'b1 && last === 1'b0) begin
      period_o <= per_cnt;
      per_cnt <= 1;
    end
    // Falling edge closes one high phase
    if (pin_i === 1'b0 && last === 1'b1) begin
      hi_len_o <= hi_cnt;
      hi_cnt <= 0;
    end
  end
endmodule

/* verif/ppg_timer_tb_top.sv */
// Self-checking testbench for the two-channel pulse pattern timer
`timescale 1ns/10ps
`include "ppg_defines.svh"
module ppg_timer_tb_top;
  import ppg_pkg::*;
  logic clk_i, srst_i, psel, penable, pwrite; // Clock, reset, APB controls
  logic [11:0] paddr; // APB address
  logic [31:0] pwdata, prdata_o, rv; // Write data, read data, last read
  logic pready_o, pslverr_o, ev; // Handshake, error, last error
  logic pulse_a_o, pulse_b_o, irq_a, irq_b; // Pins under test
  int fails, checks, hi_a, per_a, hi_b, per_b; // Counters and load readings
  ////////////////////////////////////////////////////////////////
  ppg_timer DUT (.clk_i(clk_i), .srst_i(srst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .pulse_a_o(pulse_a_o),
    .pulse_b_o(pulse_b_o), .cycle_match_irq_a_o(irq_a), .cycle_match_irq_b_o(irq_b));
  ppg_load_model LOAD_A (.clk_i(clk_i), .pin_i(pulse_a_o), .hi_len_o(hi_a), .period_o(per_a));
  ppg_load_model LOAD_B (.clk_i(clk_i), .pin_i(pulse_b_o), .hi_len_o(hi_b), .period_o(per_b));
  // Clock of 100 ns
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    // A transfer that never got its ready counts as a mismatch
    if (pready_o !== 1'b1) fails++;
    rv = prdata_o;
    ev = pslverr_o;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_i);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h000000, d});
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp, input string msg);
    apb(1'b0, a, 32'h00000000);
    chk(rv, exp, msg);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Count match pulses of one channel over n clocks
  task cnt_irq(input int n, input logic b, output int k);
    k = 0;
    repeat (n) begin
      @(posedge clk_i);
      if ((b ? irq_b : irq_a) === 1'b1) k++;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    chk(pulse_a_o, 32'h0, "idle A");
    chk(pulse_b_o, 32'h0, "idle B");
    rdc(`OFS_MODE_A, 32'h00000000, "mode reset");
    apb(1'b0, 12'h020, 32'h00000000);
    chk(ev, 32'h1, "unmapped");
  endtask
  task t_run_low;
    int k;
    wr(`OFS_MODE_A, 8'h27);
    wr(`OFS_DUTY_A, 8'h03);
    wr(`OFS_CYCLE_A, 8'h09);
    wr(`OFS_PAIR_CTRL, 8'h01);
    cyc(40);
    chk(per_a, 32'h9, "period");
    chk(hi_a, 32'h6, "duty width");
    wr(`OFS_MODE_A, 8'h67);
    rdc(`OFS_MODE_A, 32'h00000027, "mode locked");
    cnt_irq(27, 1'b0, k);
    chk(k, 32'h3, "irq count");
    wr(`OFS_PAIR_CTRL, 8'h00);
    cyc(2);
    chk(pulse_a_o, 32'h0, "stop level");
    rdc(`OFS_STATUS, 32'h00000000, "count cleared");
  endtask
  task t_run_high;
    wr(`OFS_MODE_A, 8'h67);
    cyc(2);
    chk(pulse_a_o, 32'h1, "idle high");
    wr(`OFS_PAIR_CTRL, 8'h01);
    cyc(40);
    chk(per_a, 32'h9, "period high idle");
    chk(hi_a, 32'h3, "high width");
    wr(`OFS_CYCLE_A, 8'h05);
    cyc(300);
    chk(per_a, 32'h5, "new cycle");
    chk(hi_a, 32'h3, "width after wrap");
    wr(`OFS_PAIR_CTRL, 8'h00);
  endtask
  task t_dbuf;
    wr(`OFS_MODE_A, 8'hA7);
    wr(`OFS_DUTY_A, 8'h02);
    wr(`OFS_CYCLE_A, 8'h07);
    wr(`OFS_PAIR_CTRL, 8'h01);
    cyc(30);
    chk(per_a, 32'h7, "stopped buffered write");
    wr(`OFS_CYCLE_A, 8'h03);
    wr(`OFS_DUTY_A, 8'h01);
    rdc(`OFS_CYCLE_A, 32'h00000003, "buffer readback");
    rdc(`OFS_DUTY_A, 32'h00000001, "duty buffer readback");
    cyc(30);
    chk(per_a, 32'h3, "taken at match");
    chk(hi_a, 32'h2, "duty taken at match");
    wr(`OFS_PAIR_CTRL, 8'h00);
  endtask
  task t_and;
    int k;
    wr(`OFS_MODE_A, 8'h27);
    wr(`OFS_DUTY_A, 8'h03);
    wr(`OFS_CYCLE_A, 8'h09);
    wr(`OFS_MODE_B, 8'h67);
    wr(`OFS_PAIR_CTRL, 8'h09);
    repeat (30) begin
      @(posedge clk_i);
      chk(pulse_b_o, pulse_a_o, "and of channels");
    end
    wr(`OFS_PAIR_CTRL, 8'h00);
    wr(`OFS_MODE_B, 8'h27);
    wr(`OFS_DUTY_B, 8'h01);
    wr(`OFS_CYCLE_B, 8'h04);
    wr(`OFS_PAIR_CTRL, 8'h02);
    cyc(30);
    chk(per_b, 32'h4, "period B");
    chk(hi_b, 32'h3, "width B");
    cnt_irq(20, 1'b1, k);
    chk(k, 32'h5, "irq B");
    wr(`OFS_PAIR_CTRL, 8'h00);
  endtask
  // Divided source clock: one tick every four clocks
  task t_prescale;
    wr(`OFS_MODE_A, 8'h26);
    wr(`OFS_DUTY_A, 8'h01);
    wr(`OFS_CYCLE_A, 8'h02);
    wr(`OFS_PAIR_CTRL, 8'h01);
    cyc(60);
    chk(per_a, 32'h8, "divided period");
    chk(hi_a, 32'h4, "divided width");
    wr(`OFS_PAIR_CTRL, 8'h00);
  endtask
  // Unbuffered duty write equal to the running count toggles at once
  task t_equal;
    wr(`OFS_MODE_A, 8'h27);
    wr(`OFS_DUTY_A, 8'h40);
    wr(`OFS_CYCLE_A, 8'h60);
    wr(`OFS_PAIR_CTRL, 8'h01);
    // The count stands at two on the access edge of this write
    wr(`OFS_DUTY_A, 8'h02);
    cyc(2);
    chk(pulse_a_o, 32'h1, "equal write match");
    wr(`OFS_PAIR_CTRL, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////
  task results;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    srst_i = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    fails = 0;
    checks = 0;
    repeat (3) @(posedge clk_i);
    srst_i <= 1'b0;
    @(posedge clk_i);
    t_reset;
    t_run_low;
    t_run_high;
    t_dbuf;
    t_and;
    t_prescale;
    t_equal;
    results;
  end
  // Watchdog well beyond the expected run
  initial begin
    #2000000;
    fails++;
    results;
  end
endmodule
